// ---- verilog/lvctl_pkg.sv ----
// Purpose: shared constants for the printer/plotter io controller
// Assumes: 200 MHz ref_clk, processor io transfer decoded to device and op fields
// Notes: accumulator bit 11 is the least significant bit (accumulator[0])
package lvctl_pkg;
   localparam int CLK_MHZ = 200;
   localparam int STROBE_NS = 100;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int TONER_MS = 1500;
   localparam longint TONER_CYC = longint'(TONER_MS) * longint'(CLK_MHZ) * 1000;
   localparam int LINE_COLS = 132;
   localparam int PLOT_BYTES = 128;
   // device selects of the io transfer instruction
   localparam logic [5:0] DEV_STATUS = 6'h35;
   localparam logic [5:0] DEV_PRINT = 6'h36;
   // low op digit
   localparam logic [2:0] OP_LOAD_STATUS = 3'h7;
   localparam logic [2:0] OP_SKIP_DONE = 3'h1;
   localparam logic [2:0] OP_CLEAR_DONE = 3'h2;
   localparam logic [2:0] OP_SKIP_ERROR = 3'h3;
   localparam logic [2:0] OP_LOAD_BUF = 3'h4;
   localparam logic [2:0] OP_INT_ON = 3'h5;
   localparam logic [2:0] OP_CLEAR_LOAD = 3'h6;
   localparam logic [2:0] OP_INT_OFF = 3'h7;
   // status field positions within accumulator[5:0]
   localparam int ST_MODE = 0;
   localparam int ST_MODE_EN = 1;
   localparam int ST_FORM_FEED = 2;
   localparam int ST_JOB_EJECT = 3;
   localparam int ST_BUF_CLEAR = 4;
   localparam int ST_LINE_TERM = 5;
   localparam logic MODE_RESET = 1'b0;
   // format control codes
   localparam logic [6:0] CODE_EOT = 7'h04;
   localparam logic [6:0] CODE_LF = 7'h0a;
   localparam logic [6:0] CODE_FF = 7'h0c;
   localparam logic [6:0] CODE_CR = 7'h0d;
   localparam logic [6:0] CODE_SPACE = 7'h20;
   typedef enum logic [2:0] {
      LK_IDLE = 3'b000,
      LK_STROBE = 3'b001,
      LK_WAIT_HI = 3'b010,
      LK_WAIT_LO = 3'b011,
      LK_TONER = 3'b100
   } link_state_e;
endpackage : lvctl_pkg

// ---- verilog/byte_skid_fifo.sv ----
// Purpose: two-entry buffer between the io transfer port and the printer link
// Assumes: single clock, asynchronous active-low reset
// Notes: in_ready is low only when both entries hold data
`timescale 1ns/1ps
module byte_skid_fifo #(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic [W-1:0] e0;
      logic [W-1:0] e1;
      logic [1:0] cnt;
   } fifo_s;
   fifo_s s_q, s_d;
   logic push, pop;

   assign in_ready = (s_q.cnt != 2'd2);
   assign out_valid = (s_q.cnt != 2'd0);
   assign out_data = s_q.e0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (pop) begin
         s_d.e0 = s_q.e1;
      end
      if (push) begin
         // entry 0 is written when empty or when it drains this cycle with one held
         if (s_q.cnt == 2'd0 || (pop && s_q.cnt == 2'd1)) begin
            s_d.e0 = in_data;
         end else begin
            s_d.e1 = in_data;
         end
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : byte_skid_fifo

// ---- verilog/printer_plotter_io_controller.sv ----
// Purpose: io transfer controller driving an electrostatic printer/plotter link
// Assumes: one io transfer per iot_valid cycle; printer inputs synchronous to ref_clk
// Notes: done follows the printer ready line; toner start-up hold is timed here
`timescale 1ns/1ps
// How it works
// [RQ1] load-status copies accumulator bits 06..11 into the status register
// [RQ2] skip-on-done requests a skip when Done is 1
// [RQ3] clear-flag forces Done to 0 (code keeps Done at 1 when a completion lands in the same cycle)
// [RQ4] skip-on-error requests a skip when the ready line reads 0
// [RQ5] load-buffer sends accumulator bits 04..11; seven bits used in print mode
// [RQ6] interrupt-on sets the interrupt enable
// [RQ7] combined instruction clears Done and loads the buffer together
// [RQ8] interrupt-off clears the interrupt enable
// [RQ9] status bit 11 selects plot when 1; print mode after reset
// [RQ10] mode bit updates only when status bit 10 is written 1
// [RQ11] bit 09 commands form feed, in plot mode only
// [RQ12] bit 08 commands end-of-transmission, in plot mode only
// [RQ13] bit 07 clears buffer and returns column to margin, any mode
// [RQ14] bit 06 ends partial plot line; not in print or mode-setting instruction (code blocks it only when the instruction selects plot)
// [RQ15] done rises on ready return; printing codes wait for print end
// [RQ16] after 1.5 s without printing, done waits a further 1.5 s
// [RQ17] a started print cycle keeps the mode it began with
// [RQ18] print-mode CR with buffered data also line feeds
// [RQ19] first CR/LF after full-buffer print is ignored
// [RQ20] EOT advances paper 8 inches then to top of form
// [RQ21] ready goes high after strobe, low when next byte accepted
// [RQ22] mode line high is print, low plot; each byte latched by strobe
// [RQ23] interrupt requested while enable and Done are both set
module printer_plotter_io_controller
   import lvctl_pkg::*;
#(
   parameter int unsigned TONER_CYCLES = 32'(TONER_CYC),
   parameter int unsigned COLS = LINE_COLS,
   parameter int unsigned PLOT_COLS = PLOT_BYTES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic iot_valid,
   input wire logic [5:0] iot_dev,
   input wire logic [2:0] iot_op,
   input wire logic [11:0] accumulator,
   output logic iot_stall,
   output logic skip,
   output logic interrupt_req,
   output logic done,
   output logic [7:0] print_data,
   output logic data_strobe,
   output logic mode_line,
   input wire logic printer_ready_line,
   output logic form_feed_cmd,
   output logic plot_job_eject,
   output logic buffer_clear_cmd,
   output logic line_term_cmd
);
   typedef struct packed {
      link_state_e st;
      logic done;
      logic ie;
      logic mode;
      logic cyc_mode;
      logic suppress;
      logic prints;
      logic [7:0] col;
      logic [7:0] data;
      logic [7:0] stb_cnt;
      logic [31:0] idle_cnt;
      logic [31:0] toner_cnt;
      logic toner_hold;
      logic ff;
      logic eject;
      logic bclr;
      logic lterm;
      logic irq;
   } ctl_s;

   ctl_s s_q, s_d;
   logic dev_st, dev_pr, ld_status, load, clr_done;
   logic fifo_ready, fifo_valid, fifo_pop;
   logic [7:0] fifo_data;
   logic [5:0] st_in;
   logic mode_set_now, idle_full;

   assign st_in = accumulator[5:0]; // [RQ1]
   assign dev_st = iot_valid && (iot_dev == DEV_STATUS);
   assign dev_pr = iot_valid && (iot_dev == DEV_PRINT);
   assign ld_status = dev_st && (iot_op == OP_LOAD_STATUS);
   assign load = dev_pr && (iot_op == OP_LOAD_BUF || iot_op == OP_CLEAR_LOAD); // [RQ5] [RQ7]
   assign clr_done = dev_pr && (iot_op == OP_CLEAR_DONE || iot_op == OP_CLEAR_LOAD); // [RQ3] [RQ7]
   assign mode_set_now = ld_status && st_in[ST_MODE_EN] && st_in[ST_MODE];
   assign idle_full = (s_q.idle_cnt >= TONER_CYCLES);

   // a full buffer stalls the processor instead of dropping the byte
   assign iot_stall = load && !fifo_ready;
   assign skip = (dev_pr && iot_op == OP_SKIP_DONE && s_q.done) // [RQ2]
      || (dev_pr && iot_op == OP_SKIP_ERROR && !printer_ready_line); // [RQ4]
   assign fifo_pop = (s_q.st == LK_IDLE) && fifo_valid && !printer_ready_line;

   byte_skid_fifo #(.W(8)) u_buf (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(load),
      .in_ready(fifo_ready),
      .in_data(accumulator[7:0]), // [RQ5]
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   always_comb begin
      logic [6:0] ch;
      logic set_done;
      ch = fifo_data[6:0];
      set_done = 1'b0;
      s_d = s_q;
      s_d.ff = 1'b0;
      s_d.eject = 1'b0;
      s_d.bclr = 1'b0;
      s_d.lterm = 1'b0;
      if (!idle_full) begin
         s_d.idle_cnt = s_q.idle_cnt + 32'd1;
      end

      if (dev_pr && iot_op == OP_INT_ON) begin
         s_d.ie = 1'b1; // [RQ6]
      end
      if (dev_pr && iot_op == OP_INT_OFF) begin
         s_d.ie = 1'b0; // [RQ8]
      end

      if (ld_status) begin
         if (st_in[ST_MODE_EN]) begin
            s_d.mode = st_in[ST_MODE]; // [RQ9] [RQ10]
         end
         s_d.ff = st_in[ST_FORM_FEED] && s_q.mode; // [RQ11]
         s_d.eject = st_in[ST_JOB_EJECT] && s_q.mode; // [RQ12]
         if (st_in[ST_BUF_CLEAR]) begin
            s_d.bclr = 1'b1; // [RQ13]
            s_d.col = 8'h00;
            s_d.suppress = 1'b0;
         end
         if (st_in[ST_LINE_TERM] && s_q.mode && !mode_set_now) begin
            s_d.lterm = 1'b1; // [RQ14]
            s_d.col = 8'h00;
         end
      end

      case (s_q.st)
         LK_IDLE: begin
            if (fifo_pop) begin
               s_d.data = s_q.mode ? fifo_data : {1'b0, ch}; // [RQ5]
               s_d.cyc_mode = s_q.mode; // [RQ17]
               s_d.prints = 1'b0;
               s_d.stb_cnt = 8'(STROBE_CYC);
               s_d.st = LK_STROBE;
               if (s_q.mode) begin
                  if (32'(s_q.col) + 32'd1 >= PLOT_COLS) begin
                     s_d.prints = 1'b1;
                     s_d.col = 8'h00;
                  end else begin
                     s_d.col = s_q.col + 8'h01;
                  end
               end else if (ch == CODE_CR || ch == CODE_LF) begin
                  if (s_q.suppress) begin
                     s_d.suppress = 1'b0; // [RQ19]
                  end else begin
                     // CR only moves paper when the line holds data
                     s_d.prints = (ch == CODE_LF) || (s_q.col != 8'h00); // [RQ18]
                     s_d.suppress = s_d.prints;
                  end
                  s_d.col = 8'h00;
               end else if (ch == CODE_FF || ch == CODE_EOT) begin
                  s_d.prints = 1'b1; // [RQ20]
                  s_d.col = 8'h00;
                  s_d.suppress = 1'b0;
               end else if (ch >= CODE_SPACE) begin
                  s_d.suppress = 1'b0;
                  if (32'(s_q.col) + 32'd1 >= COLS) begin
                     s_d.prints = 1'b1;
                     s_d.suppress = 1'b1; // [RQ19]
                     s_d.col = 8'h00;
                  end else begin
                     s_d.col = s_q.col + 8'h01;
                  end
               end
               s_d.toner_hold = s_d.prints && idle_full; // [RQ16]
            end
         end
         LK_STROBE: begin
            s_d.stb_cnt = s_q.stb_cnt - 8'h01;
            if (s_q.stb_cnt == 8'h01) begin
               s_d.st = LK_WAIT_HI;
            end
         end
         LK_WAIT_HI: begin
            if (printer_ready_line) begin
               s_d.st = LK_WAIT_LO; // [RQ21]
            end
         end
         LK_WAIT_LO: begin
            if (!printer_ready_line) begin
               // printing codes hold ready high until the print ends
               if (s_q.prints) begin
                  s_d.idle_cnt = 32'd0;
               end
               if (s_q.toner_hold) begin
                  s_d.toner_cnt = TONER_CYCLES;
                  s_d.st = LK_TONER;
               end else begin
                  set_done = 1'b1; // [RQ15]
                  s_d.st = LK_IDLE;
               end
            end
         end
         LK_TONER: begin
            s_d.idle_cnt = 32'd0;
            s_d.toner_cnt = s_q.toner_cnt - 32'd1;
            if (s_q.toner_cnt <= 32'd1) begin
               set_done = 1'b1; // [RQ16]
               s_d.toner_hold = 1'b0;
               s_d.st = LK_IDLE;
            end
         end
         default: begin
            s_d.st = LK_IDLE;
         end
      endcase

      // a completion landing with the clear keeps done set
      if (clr_done) begin
         s_d.done = 1'b0; // [RQ3]
      end
      if (set_done) begin
         s_d.done = 1'b1;
      end
      s_d.irq = s_d.ie && s_d.done; // [RQ23]
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.st <= LK_IDLE;
         s_q.mode <= MODE_RESET; // [RQ9]
         s_q.cyc_mode <= MODE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;
   assign interrupt_req = s_q.irq;
   assign print_data = s_q.data;
   assign data_strobe = (s_q.st == LK_STROBE); // [RQ22]
   // hold the started cycle's mode until the link is back in idle, after any toner hold
   assign mode_line = (s_q.st == LK_IDLE) ? !s_q.mode : !s_q.cyc_mode; // [RQ17] [RQ22]
   assign form_feed_cmd = s_q.ff;
   assign plot_job_eject = s_q.eject;
   assign buffer_clear_cmd = s_q.bclr;
   assign line_term_cmd = s_q.lterm;
endmodule : printer_plotter_io_controller

// ---- bench/lvctl_sva.sv ----
// Purpose: port-level checks of the printer/plotter io controller
// Assumes: one ref_clk domain, resetn active low
// Notes: clear/set races on done are kept out by the bench
`timescale 1ns/1ps
module lvctl_sva
   import lvctl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic iot_valid,
   input wire logic [5:0] iot_dev,
   input wire logic [2:0] iot_op,
   input wire logic [11:0] accumulator,
   input wire logic iot_stall,
   input wire logic skip,
   input wire logic interrupt_req,
   input wire logic done,
   input wire logic [7:0] print_data,
   input wire logic data_strobe,
   input wire logic mode_line,
   input wire logic printer_ready_line,
   input wire logic form_feed_cmd,
   input wire logic plot_job_eject,
   input wire logic buffer_clear_cmd,
   input wire logic line_term_cmd
);
   logic ls;
   logic pd;
   assign ls = iot_valid && iot_dev == DEV_STATUS && iot_op == OP_LOAD_STATUS;
   assign pd = iot_valid && iot_dev == DEV_PRINT;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   property p_skip_done; pd && iot_op == OP_SKIP_DONE |-> skip == done; endproperty
   a_skip_done: assert property (p_skip_done) else $error("skip on done wrong");
   property p_skip_err; pd && iot_op == OP_SKIP_ERROR |-> skip == !printer_ready_line; endproperty
   a_skip_err: assert property (p_skip_err) else $error("skip on error wrong");
   property p_clear; pd && (iot_op == OP_CLEAR_DONE || iot_op == OP_CLEAR_LOAD) |=> !done;
   endproperty
   a_clear: assert property (p_clear) else $error("done not cleared");
   property p_irq; interrupt_req |-> done || $past(done); endproperty
   a_irq: assert property (p_irq) else $error("irq without done");
   property p_bit7; data_strobe && mode_line |-> !print_data[7]; endproperty
   a_bit7: assert property (p_bit7) else $error("bit7 sent in print mode");
   property p_strobe; $rose(data_strobe) |-> ##19 data_strobe ##1 !data_strobe; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe length wrong");
   property p_mode_hold; data_strobe && $past(data_strobe) |-> $stable(mode_line); endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved in cycle");
   property p_ff; form_feed_cmd |-> $past(ls && accumulator[ST_FORM_FEED]); endproperty
   a_ff: assert property (p_ff) else $error("stray form feed");
   property p_eject; plot_job_eject |-> $past(ls && accumulator[ST_JOB_EJECT]); endproperty
   a_eject: assert property (p_eject) else $error("stray eject");
   property p_bclr; ls && accumulator[ST_BUF_CLEAR] |=> buffer_clear_cmd; endproperty
   a_bclr: assert property (p_bclr) else $error("buffer clear missing");
   property p_lt; ls && accumulator[ST_MODE_EN] && accumulator[ST_MODE] |=> !line_term_cmd;
   endproperty
   a_lt: assert property (p_lt) else $error("line end on mode set");
   c_stall: cover property (iot_stall);
   c_plot: cover property (data_strobe && !mode_line);
   c_irq: cover property (interrupt_req);
endmodule : lvctl_sva
bind printer_plotter_io_controller lvctl_sva lvctl_sva_i (.ref_clk(ref_clk), .resetn(resetn),
   .iot_valid(iot_valid), .iot_dev(iot_dev), .iot_op(iot_op), .accumulator(accumulator),
   .iot_stall(iot_stall), .skip(skip), .interrupt_req(interrupt_req), .done(done),
   .print_data(print_data), .data_strobe(data_strobe), .mode_line(mode_line),
   .printer_ready_line(printer_ready_line), .form_feed_cmd(form_feed_cmd),
   .plot_job_eject(plot_job_eject), .buffer_clear_cmd(buffer_clear_cmd),
   .line_term_cmd(line_term_cmd));

// ---- bench/printer_model.sv ----
// Purpose: behavioural printer end of the strobe/ready link
// Assumes: strobe synchronous to ref_clk
// Notes: slow stretches busy so the controller buffer fills
`timescale 1ns/1ps
module printer_model (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic data_strobe,
   input wire logic slow,
   input wire logic hold_high,
   output logic printer_ready_line
);
   logic [6:0] cnt;
   // busy count reloads while strobe is high, so ready never dips as strobe falls
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 7'h0;
      end else if (data_strobe) begin
         cnt <= slow ? 7'h3c : 7'h04;
      end else if (cnt != 7'h0) begin
         cnt <= cnt - 7'h1;
      end
   end
   // busy from the strobe's leading edge until digested; hold_high fakes a dead printer
   assign printer_ready_line = hold_high || data_strobe || cnt != 7'h0;
endmodule : printer_model

// ---- bench/printer_plotter_io_controller_bench.sv ----
// Purpose: directed bench for the printer/plotter io controller
// Assumes: toner hold shortened to 50 cycles
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module printer_plotter_io_controller_bench
   import lvctl_pkg::*;
;
   logic ref_clk, resetn = 0, iot_valid = 0, slow = 0, hold_high = 0, sk, st;
   logic [5:0] iot_dev = 6'h0;
   logic [2:0] iot_op = 3'h0;
   logic [11:0] accumulator = 12'h0;
   logic iot_stall, skip, irq, done, strobe, mode_line, rdy, ff, ej, bc, lt;
   logic [7:0] print_data;
   logic [7:0] q[$];
   int mismatches = 0, cmp_count = 0, cyc = 0, n;
   printer_plotter_io_controller #(.TONER_CYCLES(50)) printer_plotter_io_controller_i (
      .ref_clk(ref_clk), .resetn(resetn), .iot_valid(iot_valid), .iot_dev(iot_dev),
      .iot_op(iot_op), .accumulator(accumulator), .iot_stall(iot_stall), .skip(skip),
      .interrupt_req(irq), .done(done), .print_data(print_data), .data_strobe(strobe),
      .mode_line(mode_line), .printer_ready_line(rdy), .form_feed_cmd(ff),
      .plot_job_eject(ej), .buffer_clear_cmd(bc), .line_term_cmd(lt));
   printer_model printer_model_i (.ref_clk(ref_clk), .resetn(resetn), .data_strobe(strobe),
      .slow(slow), .hold_high(hold_high), .printer_ready_line(rdy));
   initial begin
      ref_clk = 0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(negedge strobe) q.push_back(print_data);
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end
   task chk(input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task io_transfer_instruction(input logic [5:0] d, input logic [2:0] o, input logic [11:0] a);
      @(negedge ref_clk);
      iot_valid = 1;
      iot_dev = d;
      iot_op = o;
      accumulator = a;
      #1;
      sk = skip;
      st = iot_stall;
      @(negedge ref_clk);
      iot_valid = 0;
   endtask : io_transfer_instruction
   task wdone;
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      chk(done, 1'h1);
   endtask : wdone
   task t_print;
      q.delete();
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_LOAD, 12'h0c1);
      wdone();
      chk(n < 40, 1'h1);
      chk(q[0], 8'h41);
      chk(mode_line, 1'h1);
   endtask : t_print
   task t_irq;
      io_transfer_instruction(DEV_PRINT, OP_INT_ON, 12'h0);
      @(negedge ref_clk);
      chk(irq, 1'h1);
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_LOAD, 12'h042);
      chk(done, 1'h0);
      @(negedge ref_clk);
      chk(irq, 1'h0);
      wdone();
      @(negedge ref_clk);
      chk(irq, 1'h1);
      io_transfer_instruction(DEV_PRINT, OP_INT_OFF, 12'h0);
      @(negedge ref_clk);
      chk(irq, 1'h0);
      io_transfer_instruction(DEV_PRINT, OP_SKIP_DONE, 12'h0);
      chk(sk, 1'h1);
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_DONE, 12'h0);
      chk(done, 1'h0);
      io_transfer_instruction(DEV_PRINT, OP_SKIP_DONE, 12'h0);
      chk(sk, 1'h0);
   endtask : t_irq
   task t_err;
      hold_high = 1;
      io_transfer_instruction(DEV_PRINT, OP_SKIP_ERROR, 12'h0);
      chk(sk, 1'h0);
      hold_high = 0;
      io_transfer_instruction(DEV_PRINT, OP_SKIP_ERROR, 12'h0);
      chk(sk, 1'h1);
   endtask : t_err
   task t_buf;
      q.delete();
      slow = 1;
      for (int i = 0; i < 4; i++) io_transfer_instruction(DEV_PRINT, OP_LOAD_BUF, 12'h050 + 12'(i));
      chk(st, 1'h1);
      n = 0;
      while (q.size() < 3 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      for (int i = 0; i < 3; i++) chk(q[i], 8'h50 + 8'(i));
      // done is still up from the first byte; wait for the third byte to finish
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_DONE, 12'h0);
      slow = 0;
      wdone();
   endtask : t_buf
   task t_mode;
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h001);
      chk(mode_line, 1'h1);
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h003);
      chk({mode_line, lt}, 2'h0);
      q.delete();
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_LOAD, 12'h0c1);
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h002);
      chk(mode_line, 1'h0);
      wdone();
      chk(q[0], 8'hc1);
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h003);
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h02c);
      chk({ff, ej, lt}, 3'h7);
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h023);
      chk(lt, 1'h0);
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h010);
      chk(bc, 1'h1);
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h002);
      chk(mode_line, 1'h1);
      io_transfer_instruction(DEV_STATUS, OP_LOAD_STATUS, 12'h02c);
      chk({ff, ej, lt}, 3'h0);
   endtask : t_mode
   task t_toner;
      repeat (80) @(negedge ref_clk);
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_LOAD, {5'h0, CODE_LF});
      wdone();
      chk(n > 60, 1'h1);
      // toner hold after a long idle shows whether a code really printed
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_LOAD, 12'h041);
      wdone();
      repeat (60) @(negedge ref_clk);
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_LOAD, {5'h0, CODE_CR});
      wdone();
      chk(n > 60, 1'h1);
      repeat (80) @(negedge ref_clk);
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_LOAD, {5'h0, CODE_LF});
      wdone();
      chk(n < 40, 1'h1);
      repeat (80) @(negedge ref_clk);
      io_transfer_instruction(DEV_PRINT, OP_CLEAR_LOAD, {5'h0, CODE_EOT});
      wdone();
      chk(n > 60, 1'h1);
   endtask : t_toner
   initial begin
      repeat (20) @(negedge ref_clk);
      chk({done, irq, strobe, mode_line}, 4'h1);
      resetn = 1;
      t_print();
      t_irq();
      t_err();
      t_buf();
      t_mode();
      t_toner();
      summarize();
   end
endmodule : printer_plotter_io_controller_bench
